//--- rtl/monitor_ctrl_pkg.sv
// Behaviour
// [RULE1] Host writes zero to converter setup bit 7; it is reserved.
// [RULE2] Force-on bit set keeps converter powered always, no settling wait.
// [RULE3] Force-on clear: power on request, wait reference settle, power off after.
// [RULE4] Temperature select field picks none, sensor one, sensor two or both.
// [RULE5] General analog input select bit adds that input to the next sequence.
// [RULE6] Cell count code n up to 5 selects cells 1..n+1, else cell 1.
// [RULE7] Auxiliary switch bit connects auxiliary pin to 5 V regulator output.
// [RULE8] Port drive bit zero pulls general pin low, one releases it.
// [RULE9] Host sets port drive bit before using the general pin as input.
// [RULE10] Port level bit reports the present level of the general pin.
// [RULE11] Sleep bit set: low current state, all fault comparators disabled.
// [RULE12] After sleep clears, wait 1 ms before voltage monitoring is active.
// [RULE13] Each sensor return bit grounds its sensor's negative input when set.
// [RULE14] Host clears sensor return bits when temperatures are not needed.
// [RULE15] Writing one to the trigger bit starts a sequence with current setup.
// [RULE16] Writable bits hold their value until rewritten or reset, read back.
package monitor_ctrl_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CONVERTER_SETUP = 8'h30;
	localparam logic [7:0] IDX_PIN_IO_SETUP = 8'h31;
	localparam logic [7:0] IDX_CONVERSION_TRIGGER = 8'h34;
	localparam logic [7:0] IDX_ENGINE_STATUS = 8'h35;

	// converter setup fields
	localparam int CS_FORCE_ON = 6;
	localparam int CS_TEMP_LSB = 4;
	localparam int CS_GENERAL = 3;
	localparam int CS_CELL_LSB = 0;
	localparam logic [7:0] CS_RESET = 8'h00;

	// pin io setup fields
	localparam int PIO_AUX = 7;
	localparam int PIO_DRIVE = 6;
	localparam int PIO_LEVEL = 5;
	localparam int PIO_SLEEP = 2;
	localparam int PIO_RET_LSB = 0;
	localparam logic [7:0] PIO_RESET = 8'h40;
	localparam logic [7:0] PIO_WRITE_MASK = 8'hC7;

	// trigger and status fields
	localparam int TRIG_BIT = 0;
	localparam int ST_BUSY = 0;
	localparam int ST_POWER = 1;
	localparam int ST_MONITOR = 2;
	localparam int ST_PENDING = 3;

	// channel order of a sequence: cells 1..6, general input, sensor one, sensor two
	localparam int NUM_CELLS = 6;
	localparam int NUM_CHANNELS = 9;

	// timing
	localparam longint CLK_HZ = 50_000_000;
	localparam longint WAKE_DELAY_US = 1000;
	localparam longint REF_SETTLE_US = 100;
	localparam int WAKE_CYCLES = int'((WAKE_DELAY_US * CLK_HZ + 999_999) / 1_000_000);
	localparam int REF_SETTLE_CYCLES = int'((REF_SETTLE_US * CLK_HZ + 999_999) / 1_000_000);

	typedef enum logic [1:0] {M_IDLE, M_POWER, M_RUN} engine_state_t;
	typedef enum logic [1:0] {W_IDLE, W_SCAN, W_WAIT} walk_state_t;

endpackage

//--- rtl/settle_timer.sv
`timescale 1ns/1ps
`default_nettype none
module settle_timer import monitor_ctrl_pkg::*; #(
	parameter int CYCLES = 16
) (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset
	input wire logic start_i, // load and run
	output logic busy_o, // counting
	output logic done_o // one-cycle pulse at expiry
);
	localparam int CW = $clog2(CYCLES + 1);

	generate
		if (CYCLES < 1) begin : g_bad
			$error("settle_timer needs at least one cycle");
		end
	endgenerate

	typedef struct packed {
		logic busy;
		logic done;
		logic [CW-1:0] cnt;
	} tstate_t;

	tstate_t s_q, s_d;

	// a restart while running reloads, so the wait counts from the last request
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (start_i) begin
			s_d.busy = 1'b1;
			s_d.cnt = CW'(CYCLES);
		end else if (s_q.busy) begin
			s_d.cnt = s_q.cnt - CW'(1);
			if (s_q.cnt == CW'(1)) begin
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign busy_o = s_q.busy;
	assign done_o = s_q.done;
endmodule
`default_nettype wire

//--- rtl/channel_walker.sv
`timescale 1ns/1ps
`default_nettype none
module channel_walker import monitor_ctrl_pkg::*; (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset
	input wire logic start_i, // begin a sequence
	input wire logic [NUM_CHANNELS-1:0] mask_i, // channels to convert
	input wire logic conversion_trigger_done_i, // converter finished a channel
	output logic [3:0] chan_o, // channel being converted
	output logic conversion_trigger_start_o, // one-cycle start to converter
	output logic busy_o, // sequence running
	output logic seq_done_o // one-cycle pulse at sequence end
);
	typedef struct packed {
		walk_state_t st;
		logic [NUM_CHANNELS-1:0] mask;
		logic [3:0] idx;
		logic start;
		logic done;
	} wstate_t;

	wstate_t s_q, s_d;

	// one channel per pass, skipping unselected ones
	always_comb begin
		s_d = s_q;
		s_d.start = 1'b0;
		s_d.done = 1'b0;
		case (s_q.st)
			W_IDLE: begin
				if (start_i) begin
					s_d.mask = mask_i;
					s_d.idx = 4'h0;
					s_d.st = W_SCAN;
				end
			end
			W_SCAN: begin
				if (s_q.idx >= 4'(NUM_CHANNELS)) begin
					s_d.done = 1'b1;
					s_d.st = W_IDLE;
				end else if (s_q.mask[s_q.idx]) begin
					s_d.start = 1'b1;
					s_d.st = W_WAIT;
				end else begin
					s_d.idx = s_q.idx + 4'h1;
				end
			end
			W_WAIT: begin
				if (conversion_trigger_done_i) begin
					s_d.idx = s_q.idx + 4'h1;
					s_d.st = W_SCAN;
				end
			end
			default: s_d.st = W_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '{st: W_IDLE, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign chan_o = s_q.idx;
	assign conversion_trigger_start_o = s_q.start;
	assign busy_o = (s_q.st != W_IDLE);
	assign seq_done_o = s_q.done;
endmodule
`default_nettype wire

//--- rtl/monitor_adc_io_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
module monitor_adc_io_control_regs import monitor_ctrl_pkg::*; #(
	parameter int WAKE_WAIT_CYCLES = WAKE_CYCLES,
	parameter int REF_WAIT_CYCLES = REF_SETTLE_CYCLES
) (
	input wire logic clk_i, // system clock, 50 MHz
	input wire logic rst_i, // synchronous reset, active high
	// classic wishbone slave
	input wire logic cyc_i, // bus cycle
	input wire logic stb_i, // strobe
	input wire logic we_i, // write enable
	input wire logic [9:0] adr_i, // byte address
	input wire logic [3:0] sel_i, // byte lanes
	input wire logic [31:0] dat_i, // write data
	output logic [31:0] dat_o, // read data
	output logic ack_o, // acknowledge
	// converter side
	output logic adc_power_o, // converter subsystem powered
	output logic [3:0] adc_chan_o, // channel to convert
	output logic adc_start_o, // one-cycle conversion start
	input wire logic adc_done_i, // one-cycle conversion finished
	// pins and switches
	output logic aux_connect_o, // aux pin tied to regulator_5v_output
	output logic gpio_o, // general pin output level
	output logic gpio_oe_o, // general pin driven
	input wire logic gpio_i, // general pin level
	output logic [1:0] sensor_return_o, // sensor_return_switch closed per sensor
	output logic sleep_o, // low quiescent state
	output logic comparators_en_o, // fault comparators enabled
	output logic monitor_active_o // voltage monitoring trusted
);
	generate
		if (WAKE_WAIT_CYCLES < 1 || REF_WAIT_CYCLES < 1) begin : g_bad
			$error("wait counts must be at least one cycle");
		end
	endgenerate

	typedef struct packed {
		logic [7:0] conversion_trigger_setup;
		logic [7:0] pin_setup;
		logic gpio_level;
		logic pending;
		engine_state_t st;
		logic power;
		logic monitor;
		logic ack;
		logic [31:0] dat;
	} rstate_t;

	rstate_t s_q, s_d;

	// channel mask for a sequence from the current converter setup
	function automatic logic [NUM_CHANNELS-1:0] channel_mask(input logic [7:0] cs);
		logic [NUM_CELLS-1:0] cells;
		logic [2:0] code;
		code = cs[CS_CELL_LSB +: 3];
		if (code <= 3'h5) begin
			cells = NUM_CELLS'((7'h02 << code) - 7'h01); // [RULE6]
		end else begin
			cells = NUM_CELLS'(1); // [RULE6]
		end
		return {cs[CS_TEMP_LSB + 1], cs[CS_TEMP_LSB], cs[CS_GENERAL], cells}; // [RULE4] [RULE5]
	endfunction

	logic [7:0] idx;
	logic req;
	logic wr;
	logic trig_wr;
	logic walk_start;
	logic walk_busy;
	logic walk_done;
	logic ref_start;
	logic ref_done;
	logic wake_start;
	logic wake_done;

	// one transfer per request; ack drops in the cycle after it was given
	assign idx = adr_i[9:2];
	assign req = cyc_i & stb_i & ~s_q.ack;
	assign wr = req & we_i & sel_i[0];
	assign trig_wr = wr & (idx == IDX_CONVERSION_TRIGGER) & dat_i[TRIG_BIT];

	always_comb begin
		s_d = s_q;
		s_d.ack = req;
		s_d.gpio_level = gpio_i; // [RULE10]
		walk_start = 1'b0;
		ref_start = 1'b0;
		wake_start = 1'b0;

		// register writes; reserved bit 7 of the setup is stored but steers nothing
		if (wr) begin
			case (idx)
				IDX_CONVERTER_SETUP: s_d.conversion_trigger_setup = dat_i[7:0]; // [RULE16] [RULE1]
				IDX_PIN_IO_SETUP: s_d.pin_setup = dat_i[7:0] & PIO_WRITE_MASK; // [RULE16]
				default: ;
			endcase
		end

		// leaving sleep restarts the reference wait
		if (s_q.pin_setup[PIO_SLEEP] && !s_d.pin_setup[PIO_SLEEP]) begin
			wake_start = 1'b1; // [RULE12]
		end
		if (s_d.pin_setup[PIO_SLEEP]) begin
			s_d.monitor = 1'b0; // [RULE11]
		end else if (wake_done) begin
			s_d.monitor = 1'b1; // [RULE12]
		end

		// a trigger that lands while busy is kept, not lost
		if (trig_wr) begin
			s_d.pending = 1'b1; // [RULE15]
		end

		case (s_q.st)
			M_IDLE: begin
				if (s_q.pending) begin
					s_d.pending = trig_wr;
					s_d.power = 1'b1;
					if (s_q.conversion_trigger_setup[CS_FORCE_ON]) begin
						walk_start = 1'b1; // [RULE2]
						s_d.st = M_RUN;
					end else begin
						ref_start = 1'b1; // [RULE3]
						s_d.st = M_POWER;
					end
				end
			end
			M_POWER: begin
				if (ref_done) begin
					walk_start = 1'b1; // [RULE3]
					s_d.st = M_RUN;
				end
			end
			M_RUN: begin
				if (walk_done) begin
					s_d.st = M_IDLE;
				end
			end
			default: s_d.st = M_IDLE;
		endcase

		// converter stays on in force mode, otherwise only while a sequence is settling or converting
		if (s_d.conversion_trigger_setup[CS_FORCE_ON] || s_d.st != M_IDLE) begin
			s_d.power = 1'b1; // [RULE2]
		end else begin
			s_d.power = 1'b0; // [RULE3]
		end

		// read data; unmapped addresses read zero and ignore writes
		s_d.dat = 32'h0000_0000;
		if (req && !we_i) begin
			case (idx)
				IDX_CONVERTER_SETUP: s_d.dat = {24'h00_0000, s_q.conversion_trigger_setup}; // [RULE16]
				IDX_PIN_IO_SETUP: begin
					s_d.dat = {24'h00_0000, s_q.pin_setup};
					s_d.dat[PIO_LEVEL] = s_q.gpio_level; // [RULE10]
				end
				IDX_CONVERSION_TRIGGER: s_d.dat = 32'h0000_0000;
				IDX_ENGINE_STATUS: begin
					s_d.dat[ST_BUSY] = (s_q.st != M_IDLE);
					s_d.dat[ST_POWER] = s_q.power;
					s_d.dat[ST_MONITOR] = s_q.monitor;
					s_d.dat[ST_PENDING] = s_q.pending;
				end
				default: s_d.dat = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '{conversion_trigger_setup: CS_RESET, pin_setup: PIO_RESET, st: M_IDLE, monitor: 1'b1, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// reference settle before converting in auto mode
	settle_timer #(
		.CYCLES(REF_WAIT_CYCLES)
	) u_ref_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(ref_start),
		.busy_o(),
		.done_o(ref_done)
	);

	// reference settle after sleep exit
	settle_timer #(
		.CYCLES(WAKE_WAIT_CYCLES)
	) u_wake_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(wake_start),
		.busy_o(),
		.done_o(wake_done)
	);

	// the mask is latched at sequence start, so later writes apply next time
	channel_walker u_walker (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(walk_start),
		.mask_i(channel_mask(s_q.conversion_trigger_setup)), // [RULE15]
		.conversion_trigger_done_i(adc_done_i),
		.chan_o(adc_chan_o),
		.conversion_trigger_start_o(adc_start_o),
		.busy_o(walk_busy),
		.seq_done_o(walk_done)
	);

	// pin and switch outputs from the stored bits; the general pin output level is a constant zero
	assign aux_connect_o = s_q.pin_setup[PIO_AUX]; // [RULE7]
	assign gpio_o = 1'b0;
	assign gpio_oe_o = ~s_q.pin_setup[PIO_DRIVE]; // [RULE8]
	assign sensor_return_o = s_q.pin_setup[PIO_RET_LSB +: 2]; // [RULE13]
	assign sleep_o = s_q.pin_setup[PIO_SLEEP]; // [RULE11]
	assign comparators_en_o = ~s_q.pin_setup[PIO_SLEEP]; // [RULE11]
	assign monitor_active_o = s_q.monitor;
	assign adc_power_o = s_q.power;
	assign ack_o = s_q.ack;
	assign dat_o = s_q.dat;

	logic unused;
	assign unused = walk_busy;
endmodule
`default_nettype wire

//--- verif/conversion_trigger_model.sv
`timescale 1ns/1ps
`default_nettype none
module conversion_trigger_model (
	input wire logic clk_i, // clock
	input wire logic rst_i, // sync reset
	input wire logic slow_i, // long conversions
	input wire logic start_i, // start pulse
	output logic done_o // finish pulse
);
	logic [3:0] cnt_q;
	// slow mode stretches each conversion so the walker must really wait
	always_ff @(posedge clk_i) begin
		done_o <= 1'b0;
		if (rst_i) begin
			cnt_q <= 4'h0;
		end else if (start_i) begin
			cnt_q <= slow_i ? 4'h8 : 4'h1;
		end else if (cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
			done_o <= (cnt_q == 4'h1);
		end
	end
endmodule
`default_nettype wire

//--- verif/ctrl_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ctrl_regs_checker import monitor_ctrl_pkg::*; #(
	parameter int WAKE_WAIT_CYCLES = 20
) (
	input wire logic clk_i, // clock
	input wire logic rst_i, // reset
	input wire logic cyc_i, // cycle
	input wire logic stb_i, // strobe
	input wire logic we_i, // write
	input wire logic [9:0] adr_i, // address
	input wire logic [3:0] sel_i, // lanes
	input wire logic [31:0] dat_i, // write data
	input wire logic ack_o, // ack
	input wire logic adc_power_o, // power
	input wire logic adc_start_o, // start
	input wire logic aux_connect_o, // aux
	input wire logic gpio_oe_o, // pin low
	input wire logic [1:0] sensor_return_o, // returns
	input wire logic sleep_o, // asleep
	input wire logic comparators_en_o, // comparators
	input wire logic monitor_active_o // monitoring
);
	localparam int WAKE_HI = WAKE_WAIT_CYCLES;
	logic take, wr_pio, wr_cs;
	// a request counts only while no ack is out
	assign take = cyc_i & stb_i & ~ack_o;
	assign wr_pio = take & we_i & sel_i[0] & (adr_i[9:2] == IDX_PIN_IO_SETUP);
	assign wr_cs = take & we_i & sel_i[0] & (adr_i[9:2] == IDX_CONVERTER_SETUP);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack; take |=> ack_o ##1 !ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack not one pulse");
	property p_aux; wr_pio ##1 1'b1 |=> aux_connect_o == $past(dat_i[PIO_AUX], 2); endproperty
	a_aux: assert property (p_aux) else $error("aux switch wrong");
	property p_drive; wr_pio ##1 1'b1 |=> gpio_oe_o != $past(dat_i[PIO_DRIVE], 2); endproperty
	a_drive: assert property (p_drive) else $error("pin drive wrong");
	property p_ret; wr_pio ##1 1'b1 |=> sensor_return_o == $past(dat_i[1:0], 2); endproperty
	a_ret: assert property (p_ret) else $error("return switch wrong");
	property p_sleep; comparators_en_o == !sleep_o && (sleep_o -> !monitor_active_o); endproperty
	a_sleep: assert property (p_sleep) else $error("comparators on in sleep");
	property p_wake; $fell(sleep_o) |-> (!monitor_active_o) [*8] ##[1:WAKE_HI] monitor_active_o; endproperty
	a_wake: assert property (p_wake) else $error("wake wait wrong");
	property p_force; wr_cs && dat_i[CS_FORCE_ON] ##1 1'b1 |=> adc_power_o; endproperty
	a_force: assert property (p_force) else $error("forced power off");
	property p_auto; $rose(adc_power_o) |-> (!adc_start_o) [*5]; endproperty
	a_auto: assert property (p_auto) else $error("no settle wait");
endmodule
bind monitor_adc_io_control_regs ctrl_regs_checker #(.WAKE_WAIT_CYCLES(WAKE_WAIT_CYCLES)) chk_inst (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
	.dat_i(dat_i), .ack_o(ack_o), .adc_power_o(adc_power_o), .adc_start_o(adc_start_o),
	.aux_connect_o(aux_connect_o), .gpio_oe_o(gpio_oe_o), .sensor_return_o(sensor_return_o),
	.sleep_o(sleep_o), .comparators_en_o(comparators_en_o), .monitor_active_o(monitor_active_o));
`default_nettype wire

//--- verif/monitor_adc_io_control_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module monitor_adc_io_control_regs_test import monitor_ctrl_pkg::*; ;
	typedef struct {logic [9:0] a; logic [7:0] d; logic ext; logic [7:0] e;} row_t;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, adc_done_i, slow, ext_low, pin, ack_o, adc_power_o, adc_start_o;
	logic aux_connect_o, gpio_o, gpio_oe_o, sleep_o, comparators_en_o, monitor_active_o;
	logic [9:0] adr_i;
	logic [3:0] sel_i, adc_chan_o;
	logic [3:0] lanes;
	logic [31:0] dat_i, dat_o;
	logic [1:0] sensor_return_o;
	int fails, n_compared;
	row_t rows[7] = '{'{10'h0C0, 8'h7F, 1'b0, 8'h7F}, '{10'h0C0, 8'h2A, 1'b0, 8'h2A},
		'{10'h0C4, 8'hC3, 1'b0, 8'hE3}, '{10'h0C4, 8'h04, 1'b0, 8'h04}, '{10'h0C4, 8'h40, 1'b1, 8'h40},
		'{10'h0D0, 8'h00, 1'b0, 8'h00}, '{10'h3FC, 8'hFF, 1'b0, 8'h00}};
	// open-drain pin with pull-up; the bench may pull it low as well
	assign pin = ext_low ? 1'b0 : (gpio_oe_o ? gpio_o : 1'b1);
	monitor_adc_io_control_regs #(.WAKE_WAIT_CYCLES(20), .REF_WAIT_CYCLES(5)) monitor_adc_io_control_regs_inst (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .adc_power_o(adc_power_o), .adc_chan_o(adc_chan_o),
		.adc_start_o(adc_start_o), .adc_done_i(adc_done_i), .aux_connect_o(aux_connect_o), .gpio_o(gpio_o),
		.gpio_oe_o(gpio_oe_o), .gpio_i(pin), .sensor_return_o(sensor_return_o), .sleep_o(sleep_o),
		.comparators_en_o(comparators_en_o), .monitor_active_o(monitor_active_o));
	conversion_trigger_model conversion_trigger_model_inst (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .start_i(adc_start_o), .done_o(adc_done_i));
	// 50 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
		n_compared++;
		if (seen !== exp) begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
			fails++;
		end
	endtask
	// one classic cycle; data is taken at the ack edge only
	task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d, output logic [7:0] r);
		int n;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		sel_i <= lanes;
		adr_i <= a;
		dat_i <= {24'h000000, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		r = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (ack_o !== 1'b1) begin
			fails++;
			end_sim();
		end
	endtask
	// program, trigger, collect converted channels until the sequence ends, or in force mode until the last start
	task automatic run_seq(input logic [7:0] s, output int lat);
		logic [8:0] m, e;
		logic [7:0] r;
		int n, got;
		m = 9'h000;
		got = 0;
		lat = 0;
		e = (s[2:0] <= 3'h5) ? (9'h001 << (s[2:0] + 3'h1)) - 9'h001 : 9'h001;
		e[8:6] = s[5:3];
		wb(1'b1, 10'h0C0, s, r);
		wb(1'b1, 10'h0D0, 8'h01, r);
		for (n = 0; n < 600; n++) begin
			@(posedge clk_i);
			if (adc_start_o === 1'b1) begin
				m[adc_chan_o] = 1'b1;
				got++;
				if (got == 1) lat = n;
			end
			if (got == $countones(e) && (s[6] || adc_power_o === 1'b0)) break;
		end
		if (n == 600) begin
			fails++;
			end_sim();
		end
		chk("chan_mask", m, e);
		chk("power", adc_power_o, s[6]);
	endtask
	initial begin
		logic [7:0] r;
		int i, la, lf;
		rst_i = 1'b1;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		adr_i = 10'h000;
		sel_i = 4'hF;
		lanes = 4'hF;
		dat_i = 32'h00000000;
		slow = 1'b0;
		ext_low = 1'b0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (rows[k]) begin
			ext_low <= rows[k].ext;
			wb(1'b1, rows[k].a, rows[k].d, r);
			wb(1'b0, rows[k].a, 8'h00, r);
			chk("readback", r, rows[k].e);
			if (rows[k].a == 10'h0C4) begin
				chk("aux", aux_connect_o, rows[k].d[7]);
				chk("pin_oe", gpio_oe_o, !rows[k].d[6]);
				chk("ret", sensor_return_o, rows[k].d[1:0]);
			end
		end
		for (i = 0; i < 8; i++) begin
			slow <= i[0];
			run_seq({2'b00, i[1:0], i[0], i[2:0]}, la);
		end
		run_seq(8'h75, lf);
		chk("settle_skip", lf < la, 1'b1);
		wb(1'b1, 10'h0C4, 8'h44, r);
		chk("asleep", {sleep_o, comparators_en_o, monitor_active_o}, 3'b100);
		wb(1'b1, 10'h0C4, 8'h40, r);
		for (i = 0; i < 40 && monitor_active_o !== 1'b1; i++) @(posedge clk_i);
		chk("wake_wait", i >= 17 && i <= 22, 1'b1);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, 10'h0C0, 8'h00, r);
		chk("cs_reset", r, 8'h00);
		wb(1'b0, 10'h0C4, 8'h00, r);
		chk("pio_reset", r, 8'h60);
		wb(1'b0, 10'h0D4, 8'h00, r);
		chk("status_reset", r, 8'h04);
		// a write with byte lane 0 off must leave the register alone
		lanes = 4'hE;
		wb(1'b1, 10'h0C0, 8'h55, r);
		lanes = 4'hF;
		wb(1'b0, 10'h0C0, 8'h00, r);
		chk("lane_off", r, 8'h00);
		// a second trigger lands mid-sequence; it is held and runs once afterwards
		slow <= 1'b1;
		wb(1'b1, 10'h0C0, 8'h40, r);
		wb(1'b1, 10'h0D0, 8'h01, r);
		wb(1'b1, 10'h0D0, 8'h01, r);
		wb(1'b0, 10'h0D4, 8'h00, r);
		chk("held_status", r, 8'h0F);
		la = 0;
		for (i = 0; i < 100; i++) begin
			@(posedge clk_i);
			if (adc_start_o === 1'b1) la++;
		end
		chk("held_start", la, 9'h001);
		end_sim();
	end
endmodule
`default_nettype wire
